/* File: core/row_repair_top.sv */
// Row repair command interpreter of the memory device.
// Summary of operation
// - Mode register 4 bit 13 sets hard repair
// - Repair mode enabled drives all data high
// - Guard key codes fixed, bank zero
// - Bad key order restarts the keys, commands other than refresh act normally
// - Broken entry: activate and write act normally
// - Four clocks of low data after write latency
// - Any high data bit aborts repair
// - Two clocks all high skip repair
// - Refresh after delay, skip repaired bank, spaced
// - Precharge after programming time, then exit delay
// - Clearing bit 13 exits after exit time
// - Multipurpose page two reports repair support
// - One spare row per bank, banks independent
// - New soft repair replaces older soft repair
// - Hard repair replaces soft repair same bank
// - Hard repair is never overwritten
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "ppr_params.svh"
module row_repair_top #(
	parameter int unsigned PGM_CYCLES_NARROW = `PPR_PGM_CYC_NARROW,
	parameter int unsigned PGM_CYCLES_WIDE   = `PPR_PGM_CYC_WIDE,
	parameter int unsigned EXIT_CYCLES       = `PPR_EXIT_CYC
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	// Command and address bus.
	input  wire ppr_pkg::cmd_t cmd_i,
	input  wire logic [1:0]   bg_i,
	input  wire logic [1:0]   ba_i,
	input  wire logic [17:0]  addr_i,
	// Write data beats of one clock.
	input  wire logic [15:0]  dq_rise_i,
	input  wire logic [15:0]  dq_fall_i,
	// Data lines driven by the device.
	output logic [15:0]       dq_o,
	output logic              dq_oe_o,
	// Device activity.
	output logic [7:0]        mpr_data_o,
	output logic              mpr_valid_o,
	output logic [15:0]       ref_bank_mask_o,
	output logic              normal_access_o,
	output logic              remap_hit_o,
	output logic              exit_busy_o,
	// Register port.
	input  wire logic [3:0]   reg_addr_i,
	input  wire logic [31:0]  reg_wdata_i,
	input  wire logic         reg_write_i,
	input  wire logic         reg_read_i,
	output logic [31:0]       reg_rdata_o
);

	// ==================================================================
	// Helpers.

	// Bank group and bank to table index; wide parts have 8 banks.
	function automatic logic [3:0] bank_idx(input logic [1:0] bg, input logic [1:0] ba, input logic wide);
		bank_idx = {(wide ? 1'b0 : bg[1]), bg[0], ba};
	endfunction

	// ==================================================================
	// State.
	ppr_pkg::seq_state_t   state;
	ppr_pkg::repair_kind_t kind [16];
	logic [17:0]           row  [16];
	logic        hard_en;
	logic        soft_en;
	logic        wide;
	logic [5:0]  wl;
	logic [3:0]  tbl_sel;
	logic [3:0]  rep_bank;
	logic [17:0] rep_row;
	logic        rep_by_wra;
	logic [5:0]  lat_cnt;
	logic [1:0]  beat;
	logic        any_high;
	logic        high_run;
	logic        last_pass;
	logic        last_skip;
	logic        last_abort;
	logic        ref_refused;
	logic [31:0] pgm_cnt;
	logic [7:0]  exit_cnt;
	logic [15:0] ref_wait;
	logic [15:0] ref_gap;
	logic [31:0] mode_exit_cnt;
	logic [1:0]  mpr_page;
	logic        commit;
	logic        commit_hard;

	key_if kif ();

	// ==================================================================
	// Decoding of the command bus.
	logic [2:0]  mr_num;
	logic        is_mr4;
	logic        cur_bank_match;
	logic [3:0]  cmd_bank;
	logic        repair_mode;
	logic [15:0] dq_mask;
	logic        beat_high;
	logic        beat_all_high;
	logic [31:0] pgm_limit;

	assign mr_num         = {bg_i[0], ba_i};
	assign is_mr4         = (cmd_i == ppr_pkg::CMD_MRS) && (mr_num == `PPR_MR_REPAIR);
	assign cmd_bank       = bank_idx(bg_i, ba_i, wide);
	assign cur_bank_match = (cmd_bank == rep_bank);
	assign repair_mode    = hard_en | soft_en;
	assign dq_mask        = wide ? 16'hFFFF : 16'h00FF;
	assign beat_high      = |((dq_rise_i | dq_fall_i) & dq_mask);
	assign beat_all_high  = ((dq_rise_i & dq_fall_i & dq_mask) == dq_mask);
	assign pgm_limit      = wide ? 32'(PGM_CYCLES_WIDE) : 32'(PGM_CYCLES_NARROW);

	// Guard key checker sees every command; held clear while repair is off.
	assign kif.cmd_valid = (cmd_i != ppr_pkg::CMD_NONE);
	assign kif.mrs0      = (cmd_i == ppr_pkg::CMD_MRS) && (mr_num == `PPR_MR_GUARD);
	assign kif.bg        = bg_i;
	assign kif.ba        = ba_i;
	assign kif.addr      = addr_i;
	assign kif.clear     = is_mr4 || state == ppr_pkg::ST_OFF;

	guard_key_check u_keys (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.kif       (kif)
	);

	// ==================================================================
	// Repair mode enables from mode register 4.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hard_en <= 1'b0;
			soft_en <= 1'b0;
		end else if (is_mr4) begin
			hard_en <= addr_i[`PPR_MR4_HARD_BIT];
			soft_en <= addr_i[`PPR_MR4_SOFT_BIT];
		end
	end

	// Exit timer runs from the write that clears both enables.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_exit_cnt <= 32'h0;
		end else if (is_mr4 && repair_mode && !addr_i[`PPR_MR4_HARD_BIT] && !addr_i[`PPR_MR4_SOFT_BIT]) begin
			mode_exit_cnt <= 32'(EXIT_CYCLES);
		end else if (mode_exit_cnt != 32'h0) begin
			mode_exit_cnt <= mode_exit_cnt - 32'h1;
		end
	end

	// ==================================================================
	// Combinational decision at the last data clock.
	logic next_any_high;
	logic next_skip;

	always_comb begin
		next_any_high = any_high | beat_high;
		next_skip     = high_run & beat_all_high;
	end

	// Repair sequencer.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state       <= ppr_pkg::ST_OFF;
			rep_bank    <= 4'h0;
			rep_row     <= 18'h0;
			rep_by_wra  <= 1'b0;
			lat_cnt     <= 6'h0;
			beat        <= 2'h0;
			any_high    <= 1'b0;
			high_run    <= 1'b0;
			last_pass   <= 1'b0;
			last_skip   <= 1'b0;
			last_abort  <= 1'b0;
			pgm_cnt     <= 32'h0;
			exit_cnt    <= 8'h0;
			commit      <= 1'b0;
			commit_hard <= 1'b0;
		end else begin
			commit <= 1'b0;
			if (is_mr4) begin
				// Any write of the enables restarts entry or leaves repair.
				if (addr_i[`PPR_MR4_HARD_BIT] || addr_i[`PPR_MR4_SOFT_BIT]) begin
					state <= ppr_pkg::ST_KEYS;
				end else begin
					state <= ppr_pkg::ST_OFF;
				end
			end else begin
				case (state)
					ppr_pkg::ST_KEYS: begin
						if (kif.passed) begin
							state <= ppr_pkg::ST_ARMED;
						end
					end
					ppr_pkg::ST_ARMED: begin
						if (cmd_i == ppr_pkg::CMD_ACT) begin
							rep_bank <= cmd_bank;
							rep_row  <= addr_i;
							state    <= ppr_pkg::ST_OPEN;
						end
					end
					ppr_pkg::ST_OPEN: begin
						if (cur_bank_match && (cmd_i == ppr_pkg::CMD_WRA ||
						    (soft_en && cmd_i == ppr_pkg::CMD_WR))) begin
							rep_by_wra <= (cmd_i == ppr_pkg::CMD_WRA);
							lat_cnt    <= wl - 6'h1;
							state      <= ppr_pkg::ST_LAT;
						end
					end
					ppr_pkg::ST_LAT: begin
						lat_cnt <= lat_cnt - 6'h1;
						if (lat_cnt <= 6'h1) begin
							beat     <= 2'h0;
							any_high <= 1'b0;
							high_run <= 1'b0;
							state    <= ppr_pkg::ST_DATA;
						end
					end
					ppr_pkg::ST_DATA: begin
						beat     <= beat + 2'h1;
						any_high <= next_any_high;
						high_run <= beat_all_high;
						if (next_skip) begin
							last_skip <= 1'b1;
						end
						if (beat == 2'(`PPR_DATA_CLKS - 1)) begin
							last_pass  <= !next_any_high;
							last_abort <= 1'b0;
							if (next_any_high) begin
								state <= ppr_pkg::ST_DONE;
							end else if (hard_en) begin
								pgm_cnt <= 32'h0;
								state   <= ppr_pkg::ST_PROGRAM;
							end else begin
								commit      <= 1'b1;
								commit_hard <= 1'b0;
								state       <= ppr_pkg::ST_DONE;
							end
						end
					end
					ppr_pkg::ST_PROGRAM: begin
						if (pgm_cnt < pgm_limit) begin
							pgm_cnt <= pgm_cnt + 32'h1;
						end
						if (cmd_i == ppr_pkg::CMD_PRE && cur_bank_match) begin
							if (pgm_cnt >= pgm_limit) begin
								exit_cnt <= 8'h0;
								state    <= ppr_pkg::ST_PRE_EXIT;
							end else begin
								last_abort <= 1'b1;
								last_pass  <= 1'b0;
								state      <= ppr_pkg::ST_DONE;
							end
						end
					end
					ppr_pkg::ST_PRE_EXIT: begin
						exit_cnt <= exit_cnt + 8'h1;
						if (exit_cnt == 8'(`PPR_PGM_EXIT_CYC - 1)) begin
							commit      <= 1'b1;
							commit_hard <= 1'b1;
							state       <= ppr_pkg::ST_DONE;
						end
					end
					ppr_pkg::ST_OFF, ppr_pkg::ST_DONE: begin
						state <= state;
					end
					default: begin
						state <= ppr_pkg::ST_OFF;
					end
				endcase
			end
		end
	end

	// ==================================================================
	// Spare row table, one entry per bank.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 16; i++) begin
				kind[i] <= ppr_pkg::KIND_NONE;
				row[i]  <= 18'h0;
			end
		end else if (commit && kind[rep_bank] != ppr_pkg::KIND_HARD) begin
			kind[rep_bank] <= commit_hard ? ppr_pkg::KIND_HARD : ppr_pkg::KIND_SOFT;
			row[rep_bank]  <= rep_row;
		end
	end

	// ==================================================================
	// Refresh gating while a hard repair write with auto-precharge runs.
	logic ref_window;
	logic ref_ok;

	assign ref_window = rep_by_wra && hard_en &&
	                    (state == ppr_pkg::ST_PROGRAM || state == ppr_pkg::ST_PRE_EXIT || state == ppr_pkg::ST_DONE);
	assign ref_ok     = !repair_mode || (ref_window && ref_wait == 16'h0 && ref_gap == 16'h0);

	// Refresh delay and spacing.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ref_wait <= 16'h0;
			ref_gap  <= 16'h0;
		end else begin
			if (state == ppr_pkg::ST_OPEN && cmd_i == ppr_pkg::CMD_WRA && cur_bank_match) begin
				ref_wait <= 16'({10'h0, wl}) + 16'(`PPR_DATA_CLKS + `PPR_WR_CYC + `PPR_RP_CYC);
			end else if (ref_wait != 16'h0) begin
				ref_wait <= ref_wait - 16'h1;
			end
			if (cmd_i == ppr_pkg::CMD_REF && ref_ok && repair_mode) begin
				ref_gap <= 16'(`PPR_REF_GAP_CYC - 1);
			end else if (ref_gap != 16'h0) begin
				ref_gap <= ref_gap - 16'h1;
			end
		end
	end

	// Refresh bank mask, excluding the bank under repair.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ref_bank_mask_o <= 16'h0;
		end else if (cmd_i == ppr_pkg::CMD_REF && ref_ok) begin
			ref_bank_mask_o <= (wide ? 16'h00FF : 16'hFFFF) &
			                   ~(repair_mode ? (16'h1 << rep_bank) : 16'h0);
		end else begin
			ref_bank_mask_o <= 16'h0;
		end
	end

	// Refused refresh flag; a refusal wins over a clear.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ref_refused <= 1'b0;
		end else if (cmd_i == ppr_pkg::CMD_REF && !ref_ok) begin
			ref_refused <= 1'b1;
		end else if (reg_write_i && reg_addr_i == `PPR_REG_STATUS && reg_wdata_i[`PPR_STAT_REFUSED]) begin
			ref_refused <= 1'b0;
		end
	end

	// ==================================================================
	// Data lines all high while repair mode is enabled.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dq_o    <= 16'h0;
			dq_oe_o <= 1'b0;
		end else begin
			dq_o    <= repair_mode ? dq_mask : 16'h0;
			dq_oe_o <= repair_mode;
		end
	end

	// Ordinary accesses and lookups of repaired rows.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			normal_access_o <= 1'b0;
			remap_hit_o     <= 1'b0;
			exit_busy_o     <= 1'b0;
		end else begin
			normal_access_o <= (!repair_mode || state == ppr_pkg::ST_KEYS) &&
			                   (cmd_i == ppr_pkg::CMD_ACT || cmd_i == ppr_pkg::CMD_WR ||
			                    cmd_i == ppr_pkg::CMD_WRA || cmd_i == ppr_pkg::CMD_RD);
			remap_hit_o     <= !repair_mode && cmd_i == ppr_pkg::CMD_ACT &&
			                   kind[cmd_bank] != ppr_pkg::KIND_NONE && row[cmd_bank] == addr_i;
			exit_busy_o     <= (mode_exit_cnt > 32'h1) || (is_mr4 && repair_mode);
		end
	end

	// ==================================================================
	// Multipurpose register page and read data.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mpr_page    <= 2'h0;
			mpr_data_o  <= 8'h0;
			mpr_valid_o <= 1'b0;
		end else begin
			if (cmd_i == ppr_pkg::CMD_MRS && mr_num == `PPR_MR_MPR) begin
				mpr_page <= addr_i[1:0];
			end
			mpr_valid_o <= (cmd_i == ppr_pkg::CMD_MPR_RD);
			mpr_data_o  <= (cmd_i == ppr_pkg::CMD_MPR_RD && mpr_page == `PPR_MPR_PAGE && ba_i == 2'h0) ?
			               `PPR_MPR0_SUPPORT : 8'h0;
		end
	end

	// ==================================================================
	// Register port writes.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wl      <= `PPR_WL_RESET;
			wide    <= 1'b0;
			tbl_sel <= 4'h0;
		end else if (reg_write_i) begin
			if (reg_addr_i == `PPR_REG_CONFIG) begin
				wl   <= (reg_wdata_i[5:0] < 6'h2) ? 6'h2 : reg_wdata_i[5:0];
				wide <= reg_wdata_i[`PPR_CFG_WIDE_BIT];
			end else if (reg_addr_i == `PPR_REG_TABLE_SEL) begin
				tbl_sel <= reg_wdata_i[3:0];
			end
		end
	end

	// Read data one cycle after the strobe; zero elsewhere.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_read_i) begin
			case (reg_addr_i)
				`PPR_REG_STATUS:     reg_rdata_o <= {16'h0, 4'(state), 4'h0, exit_busy_o, ref_refused,
				                                     last_abort, last_skip, last_pass, kif.passed,
				                                     soft_en, hard_en};
				`PPR_REG_CONFIG:     reg_rdata_o <= {23'h0, wide, 2'h0, wl};
				`PPR_REG_TABLE_SEL:  reg_rdata_o <= {28'h0, tbl_sel};
				`PPR_REG_TABLE_DATA: reg_rdata_o <= {6'h0, 2'(kind[tbl_sel]), 6'h0, row[tbl_sel]};
				default:             reg_rdata_o <= 32'h0;
			endcase
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

endmodule

/* File: core/ppr_params.svh */
// Constants of the row repair command interpreter.
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH

// ==================================================================
// Clock and timing figures in their own units.
`define PPR_CLK_MHZ         250
`define PPR_PGM_MS_NARROW   1000
`define PPR_PGM_MS_WIDE     2000
`define PPR_PGM_EXIT_NS     15
`define PPR_MODE_EXIT_US    50
`define PPR_WR_NS           15
`define PPR_RP_NS           15
`define PPR_REFI_NS         7800

// ==================================================================
// Cycle counts; least times round up.
`define PPR_PGM_CYC_NARROW  (`PPR_PGM_MS_NARROW * `PPR_CLK_MHZ * 1000)
`define PPR_PGM_CYC_WIDE    (`PPR_PGM_MS_WIDE * `PPR_CLK_MHZ * 1000)
`define PPR_PGM_EXIT_CYC    ((`PPR_PGM_EXIT_NS * `PPR_CLK_MHZ + 999) / 1000)
`define PPR_EXIT_CYC        (`PPR_MODE_EXIT_US * `PPR_CLK_MHZ)
`define PPR_WR_CYC          ((`PPR_WR_NS * `PPR_CLK_MHZ + 999) / 1000)
`define PPR_RP_CYC          ((`PPR_RP_NS * `PPR_CLK_MHZ + 999) / 1000)
`define PPR_REF_GAP_CYC     ((`PPR_REFI_NS * `PPR_CLK_MHZ + 3999) / 4000)
`define PPR_DATA_CLKS       4

// ==================================================================
// Mode register numbers, bits and guard key codes.
`define PPR_MR_GUARD        3'h0
`define PPR_MR_MPR          3'h3
`define PPR_MR_REPAIR       3'h4
`define PPR_MR4_HARD_BIT    13
`define PPR_MR4_SOFT_BIT    5
`define PPR_KEY1            5'h19
`define PPR_KEY2            5'h0F
`define PPR_KEY3            5'h17
`define PPR_KEY4            5'h07
`define PPR_KEY_LOW         7'h7F
`define PPR_MPR_PAGE        2'h2
`define PPR_MPR0_SUPPORT    8'hC0

// ==================================================================
// Register port offsets and reset values.
`define PPR_REG_STATUS      4'h0
`define PPR_REG_CONFIG      4'h1
`define PPR_REG_TABLE_SEL   4'h2
`define PPR_REG_TABLE_DATA  4'h3
`define PPR_WL_RESET        6'h09
`define PPR_CFG_WIDE_BIT    8
`define PPR_STAT_REFUSED    6
`define PPR_TBL_KIND_LSB    24

`endif

/* File: core/ppr_pkg.sv */
// Types shared by the row repair command interpreter.
package ppr_pkg;

	// Decoded command on the command bus.
	typedef enum logic [3:0] {
		CMD_NONE, CMD_MRS, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD,
		CMD_PRE, CMD_REF, CMD_ZQ, CMD_NOP, CMD_MPR_RD
	} cmd_t;

	// Kind of repair held by a bank's spare row.
	typedef enum logic [1:0] {
		KIND_NONE, KIND_SOFT, KIND_HARD
	} repair_kind_t;

	// Repair sequence states.
	typedef enum logic [3:0] {
		ST_OFF, ST_KEYS, ST_ARMED, ST_OPEN, ST_LAT,
		ST_DATA, ST_PROGRAM, ST_PRE_EXIT, ST_DONE
	} seq_state_t;

endpackage

/* File: core/key_if.sv */
// Carrier between the repair sequencer and its guard key checker.
`timescale 1ns/1ns
interface key_if;
	logic        clear;
	logic        cmd_valid;
	logic        mrs0;
	logic [1:0]  bg;
	logic [1:0]  ba;
	logic [17:0] addr;
	logic        passed;

	modport seq (output clear, output cmd_valid, output mrs0, output bg, output ba, output addr, input passed);
	modport chk (input clear, input cmd_valid, input mrs0, input bg, input ba, input addr, output passed);
endinterface

/* File: core/guard_key_check.sv */
// Guard key checker: accepts four ordered mode register 0 writes.
`timescale 1ns/1ns
`include "ppr_params.svh"
module guard_key_check (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Command view from the sequencer.
	key_if.chk       kif
);

	logic [2:0] step;

	// Expected code on address bits 11..7 for a key step.
	function automatic logic [4:0] key_code(input logic [2:0] n);
		case (n)
			3'h0: key_code = `PPR_KEY1;
			3'h1: key_code = `PPR_KEY2;
			3'h2: key_code = `PPR_KEY3;
			default: key_code = `PPR_KEY4;
		endcase
	endfunction

	// Advances on each matching key, restarts on any other command; holds once the fourth key is in.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			step <= 3'h0;
		end else if (kif.clear) begin
			step <= 3'h0;
		end else if (kif.cmd_valid && step != 3'h4) begin
			if (kif.mrs0 && kif.bg == 2'h0 && kif.ba == 2'h0 && kif.addr[6:0] == `PPR_KEY_LOW &&
			    kif.addr[11:7] == key_code(step)) begin
				step <= step + 3'h1;
			end else begin
				step <= 3'h0;
			end
		end
	end

	// The sequence is qualified once all four keys are in.
	assign kif.passed = (step == 3'h4);

endmodule

/* File: testbench/ppr_checker.sv */
// Concurrent checks on the row repair block's ports.
`timescale 1ns/1ns
module ppr_checker (
	// Clock and reset.
	input wire logic          clk_i,
	input wire logic          reset_n_i,
	// Command bus.
	input wire ppr_pkg::cmd_t cmd_i,
	input wire logic [1:0]    bg_i,
	input wire logic [1:0]    ba_i,
	input wire logic [17:0]   addr_i,
	// Device outputs.
	input wire logic [15:0]   dq_o,
	input wire logic          dq_oe_o,
	input wire logic          mpr_valid_o,
	input wire logic [15:0]   ref_bank_mask_o,
	input wire logic          normal_access_o,
	input wire logic          exit_busy_o
);
	localparam int REF_GAP = 488;
	int gap;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Cycles since the last accepted refresh, saturating.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gap <= 1000;
		end else if (ref_bank_mask_o != 16'h0000) begin
			gap <= 1;
		end else if (gap < 1000) begin
			gap <= gap + 1;
		end
	end
	// A write to the repair mode register.
	sequence mr4_write;
		cmd_i == ppr_pkg::CMD_MRS && bg_i[0] && ba_i == 2'h0;
	endsequence
	sequence mr4_clear;
		mr4_write ##0 (!addr_i[13] && !addr_i[5]);
	endsequence
	hard_enable_a: assert property (mr4_write ##0 addr_i[13] |-> ##2 dq_oe_o)
		else $error("data lines not driven");
	drive_high_a: assert property (dq_oe_o |-> dq_o[7:0] == 8'hFF)
		else $error("data lines not high");
	repair_off_a: assert property (mr4_clear |-> ##2 !dq_oe_o && dq_o == 16'h0000)
		else $error("data lines still driven");
	exit_wait_a: assert property (mr4_clear ##0 dq_oe_o |-> ##[1:2] exit_busy_o)
		else $error("exit time did not start");
	mpr_answer_a: assert property (cmd_i == ppr_pkg::CMD_MPR_RD |=> mpr_valid_o)
		else $error("no read answer");
	ref_cause_a: assert property (ref_bank_mask_o != 16'h0000 |-> $past(cmd_i) == ppr_pkg::CMD_REF)
		else $error("mask without refresh");
	ref_skip_bank_a: assert property ($past(dq_oe_o) && ref_bank_mask_o != 16'h0000
		|-> ref_bank_mask_o != 16'hFFFF && ref_bank_mask_o != 16'h00FF)
		else $error("repair bank refreshed");
	ref_spacing_a: assert property (dq_oe_o && ref_bank_mask_o != 16'h0000 |-> gap >= REF_GAP)
		else $error("refreshes too close");
	plain_access_a: assert property (normal_access_o
		|-> $past(cmd_i) inside {ppr_pkg::CMD_ACT, ppr_pkg::CMD_WR, ppr_pkg::CMD_WRA, ppr_pkg::CMD_RD})
		else $error("access without command");
endmodule
bind row_repair_top ppr_checker u_ppr_checker (.*);

/* File: testbench/ddr_ctrl_model.sv */
// Memory controller model issuing repair sequences.
`timescale 1ns/1ns
module ddr_ctrl_model #(
	parameter int GAP = 4,
	parameter int PGM = 20
) (
	// Clock.
	input wire logic      clk_i,
	// Command bus and write data.
	output ppr_pkg::cmd_t cmd_o,
	output logic [1:0]    bg_o,
	output logic [1:0]    ba_o,
	output logic [17:0]   addr_o,
	output logic [15:0]   dq_rise_o,
	output logic [15:0]   dq_fall_o
);
	logic drv = 1'b0;
	// Bus idle at time zero.
	initial begin
		cmd_o = ppr_pkg::CMD_NONE;
		{bg_o, ba_o, addr_o} = '0;
		{dq_rise_o, dq_fall_o} = 32'hA5A55A5A;
	end
	// Idle data lines toggle so stale beats never look valid.
	always @(posedge clk_i) begin
		if (!drv) {dq_rise_o, dq_fall_o} <= ~{dq_rise_o, dq_fall_o};
	end
	// One command cycle, then idle with the address inverted.
	task automatic cyc(input ppr_pkg::cmd_t c, input logic [1:0] g, input logic [1:0] b, input logic [17:0] a);
		@(posedge clk_i);
		cmd_o <= c;
		{bg_o, ba_o, addr_o} <= {g, b, a};
		@(posedge clk_i);
		cmd_o <= ppr_pkg::CMD_NONE;
		addr_o <= ~a;
	endtask
	// Mode register write; register number on bg[0] and ba.
	task automatic mrs(input logic [2:0] r, input logic [17:0] a);
		cyc(ppr_pkg::CMD_MRS, {1'b0, r[2]}, r[1:0], a);
	endtask
	// Guard key n, upper bits don't care, then the gap.
	task automatic key(input int n);
		logic [4:0] k[4] = '{5'h19, 5'h0F, 5'h17, 5'h07};
		mrs(3'h0, {6'h2A, k[n], 7'h7F});
		repeat (GAP) @(posedge clk_i);
	endtask
	// One repair kind on, banks idle, four keys in order.
	task automatic enter(input logic hard);
		mrs(3'h4, hard ? 18'h02000 : 18'h00020);
		repeat (GAP) @(posedge clk_i);
		for (int n = 0; n < 4; n++) begin
			key(n);
		end
	endtask
	// Activate, write, four data clocks after wl; hi picks beats of v.
	task automatic write(input ppr_pkg::cmd_t w, input logic [3:0] bk, input logic [17:0] row, input int wl,
		input logic [7:0] hi, input logic [15:0] v);
		cyc(ppr_pkg::CMD_ACT, bk[3:2], bk[1:0], row);
		repeat (GAP) @(posedge clk_i);
		cyc(w, bk[3:2], bk[1:0], 18'h00400);
		repeat (wl - 1) @(posedge clk_i);
		drv = 1'b1;
		for (int i = 0; i < 8; i += 2) begin
			dq_rise_o <= hi[i] ? v : 16'h0000;
			dq_fall_o <= hi[i + 1] ? v : 16'h0000;
			@(posedge clk_i);
		end
		drv = 1'b0;
	endtask
	// Precharge after programming time, then exit time.
	task automatic finish(input logic [3:0] bk);
		repeat (PGM + GAP) @(posedge clk_i);
		cyc(ppr_pkg::CMD_PRE, bk[3:2], bk[1:0], 18'h0);
		repeat (4 + GAP) @(posedge clk_i);
	endtask
	// Leave repair, wait, restore mode register 0.
	task automatic leave(input int ex);
		mrs(3'h4, 18'h0);
		repeat (ex + GAP) @(posedge clk_i);
		mrs(3'h0, 18'h0);
	endtask
endmodule

/* File: testbench/row_repair_top_tb.sv */
// Self-checking bench of the row repair block.
`timescale 1ns/1ns
module row_repair_top_tb;
	localparam int EXIT = 10;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	ppr_pkg::cmd_t cmd_i;
	logic [1:0] bg_i, ba_i;
	logic [17:0] addr_i;
	logic [15:0] dq_rise_i, dq_fall_i, dq_o, ref_bank_mask_o;
	logic [7:0] mpr_data_o;
	logic dq_oe_o, mpr_valid_o, normal_access_o, remap_hit_o, exit_busy_o;
	logic [3:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic reg_write_i, reg_read_i;
	int failures = 0, n_compared = 0;
	// 250 MHz clock.
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	row_repair_top #(.PGM_CYCLES_NARROW(20), .PGM_CYCLES_WIDE(40), .EXIT_CYCLES(EXIT)) u_row_repair_top (.*);
	ddr_ctrl_model u_ddr_ctrl_model (.clk_i, .cmd_o(cmd_i), .bg_o(bg_i), .ba_o(ba_i), .addr_o(addr_i),
		.dq_rise_o(dq_rise_i), .dq_fall_o(dq_fall_i));
	// Compare one value and count it.
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Register write, one strobe cycle.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask
	// Register read; data checked in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
		@(posedge clk_i);
		{reg_addr_i, reg_read_i} <= {a, 1'b1};
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		#1 cmp(what, exp, reg_rdata_o & m);
	endtask
	// Full repair pass on one bank, spare row read back.
	task automatic go(input logic hard, input logic [3:0] bk, input logic [17:0] row, input logic [31:0] exp,
		input logic [7:0] hi = 8'h00, input logic [15:0] v = 16'h0);
		u_ddr_ctrl_model.enter(hard);
		u_ddr_ctrl_model.write(hard ? ppr_pkg::CMD_WRA : ppr_pkg::CMD_WR, bk, row, 9, hi, v);
		u_ddr_ctrl_model.finish(bk);
		u_ddr_ctrl_model.leave(EXIT);
		wr(4'h2, {28'h0, bk});
		rd(4'h3, 32'h0303FFFF, exp, "spare row");
	endtask
	// Verdict and end of run.
	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog beyond the expected run length.
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		{reg_addr_i, reg_wdata_i, reg_write_i, reg_read_i} = '0;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(4'h0, 32'hFFFFFFFF, 32'h0, "status");
		rd(4'hF, 32'hFFFFFFFF, 32'h0, "unmapped");
		wr(4'h1, 32'h1);
		rd(4'h1, 32'h3F, 32'h2, "latency floor");
		wr(4'h1, 32'h9);
		u_ddr_ctrl_model.mrs(3'h3, 18'h00006);
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_MPR_RD, 2'h0, 2'h0, 18'h0);
		#1 cmp("mpr data", 32'hC0, {24'h0, mpr_data_o});
		u_ddr_ctrl_model.mrs(3'h3, 18'h0);
		$display("test registers done");
		u_ddr_ctrl_model.mrs(3'h4, 18'h02000);
		@(posedge clk_i);
		#1 cmp("dq drive", 32'h000100FF, {15'h0, dq_oe_o, dq_o});
		for (int n = 0; n < 4; n++) begin
			u_ddr_ctrl_model.key(n < 2 ? 1 - n : n);
		end
		rd(4'h0, 32'h4, 32'h0, "keys out of order");
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_ACT, 2'h1, 2'h2, 18'h00123);
		#1 cmp("plain access", 32'h1, {31'h0, normal_access_o});
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_PRE, 2'h1, 2'h2, 18'h0);
		u_ddr_ctrl_model.key(0);
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_NOP, 2'h0, 2'h0, 18'h0);
		for (int n = 0; n < 4; n++) begin
			u_ddr_ctrl_model.key(n);
		end
		rd(4'h0, 32'h7, 32'h5, "keys accepted");
		u_ddr_ctrl_model.write(ppr_pkg::CMD_WRA, 4'h6, 18'h00123, 9, 8'h00, 16'h0);
		repeat (10) @(posedge clk_i);
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_REF, 2'h0, 2'h0, 18'h0);
		#1 cmp("refresh banks", 32'hFFBF, {16'h0, ref_bank_mask_o});
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_REF, 2'h0, 2'h0, 18'h0);
		#1 cmp("early refresh", 32'h0, {16'h0, ref_bank_mask_o});
		rd(4'h0, 32'h40, 32'h40, "refresh refused");
		wr(4'h0, 32'h40);
		rd(4'h0, 32'h40, 32'h0, "refused cleared");
		u_ddr_ctrl_model.finish(4'h6);
		u_ddr_ctrl_model.leave(EXIT);
		#1 cmp("dq released", 32'h0, {15'h0, dq_oe_o, dq_o});
		wr(4'h2, 32'h6);
		rd(4'h3, 32'h0303FFFF, 32'h02000123, "hard entry");
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_ACT, 2'h1, 2'h2, 18'h00123);
		#1 cmp("remap hit", 32'h1, {31'h0, remap_hit_o});
		u_ddr_ctrl_model.cyc(ppr_pkg::CMD_PRE, 2'h1, 2'h2, 18'h0);
		$display("test entry and hard repair done");
		go(0, 4'h3, 18'h00011, 32'h01000011);
		go(0, 4'h3, 18'h00022, 32'h01000022);
		go(0, 4'h3, 18'h00033, 32'h01000022, 8'h08, 16'h0010);
		go(1, 4'h3, 18'h00044, 32'h01000022, 8'h3C, 16'hFFFF);
		rd(4'h0, 32'h10, 32'h10, "skip flag");
		go(1, 4'h3, 18'h00055, 32'h02000055);
		go(0, 4'h3, 18'h00066, 32'h02000055);
		go(1, 4'h3, 18'h00077, 32'h02000055);
		go(0, 4'h9, 18'h00099, 32'h01000099);
		wr(4'h2, 32'h3);
		rd(4'h3, 32'h0303FFFF, 32'h02000055, "other bank");
		$display("test spare rows done");
		tally_and_finish();
	end
endmodule
